// ==== logic/ssc_pkg.sv ====
// Purpose: Shared constants and types for the sensor status/control bank
// Assumes: 10 MHz core clock, AHB-Lite word registers
// Notes: Register offsets are indices; byte address is index times four
package ssc_pkg;
  // ****************************************
  // Clock and watchdog timing
  // ****************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int WDOG_TIME_MS = 250;
  // Longest time, so the count rounds down
  localparam int WDOG_CYCLES = WDOG_TIME_MS * (CLK_HZ / 1000);
  localparam int RST_SYNC_LEN = 2;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [7:0] IDX_WDOG_EN = 8'hBE;
  localparam logic [7:0] IDX_BUS_SEL = 8'hBF;
  localparam logic [7:0] IDX_NVM_CTRL = 8'hC0;
  localparam logic [7:0] IDX_STATUS_ONE = 8'hC1;
  localparam logic [7:0] IDX_STATUS_TWO = 8'hC2;
  localparam logic [7:0] IDX_CTRL_ONE = 8'hD0;
  localparam logic [7:0] IDX_WDOG_KICK = 8'hD1;
  localparam logic [7:0] IDX_SATURATION_TIME = 8'hD2;
  localparam logic [7:0] IDX_SER_LEN = 8'hD3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_BUS_MODE = 0;
  localparam int BIT_PROG = 0;
  localparam int BIT_RELOAD = 1;
  localparam int BIT_OSC_WATCHDOG_ENABLE = 0;
  localparam int BIT_SW_WATCHDOG_ENABLE = 1;
  localparam int BIT_DRV_FLT_EN = 0;

  // ****************************************
  // Reset values and limits
  // ****************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] SER_MAX_BYTES = 4'h8;
  localparam logic [15:0] SAT_CNT_MAX = 16'hFFFF;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // Analogue and self-test condition inputs
  typedef struct packed {
    logic trimCorrupt;
    logic selftestDone;
    logic selftestPass;
    logic supplyOv;
    logic avddUv;
    logic avddOc;
    logic biasOc;
    logic regReady;
    logic oscAbnormal;
    logic drvAFault;
    logic drvBFault;
    logic echoBelow;
    logic burstEnd;
  } ssc_flags_t;

  // Saturation timing states
  typedef enum logic [2:0] {
    SAT_IDLE = 3'b001,
    SAT_WAIT = 3'b010,
    SATURATION_DONE = 3'b100
  } ssc_sat_state_t;
endpackage : ssc_pkg

// ==== logic/ssc_status_control_regs.sv ====
// Purpose: Status and control register bank of an ultrasonic front-end
// Assumes: AHB-Lite single word transfers, one clock domain
// Notes: Condition inputs are asynchronous and pass two flip-flops
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
module ssc_status_control_regs #(
  parameter int SW_WDOG_CYCLES = ssc_pkg::WDOG_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Condition inputs from analogue and test blocks
  input wire ssc_pkg::ssc_flags_t flagsIn,
  // Nonvolatile memory engine, same clock
  input wire logic nvmProgramDone,
  output logic nvmReloadStart,
  output logic nvmProgramStart,
  // Bus routing and serial engine
  output logic busModeSerial,
  output logic [3:0] serialXferLen,
  // Core reset request
  output logic coreReset
);
  // ****************************************
  // Reset release
  // ****************************************
  logic [ssc_pkg::RST_SYNC_LEN-1:0] rstPipe; // Release pipeline
  logic rstSync; // Reset used by all other logic

  // Assert at once, release after two edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= '0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync = rstPipe[ssc_pkg::RST_SYNC_LEN-1];

  // ****************************************
  // Condition synchronisers
  // ****************************************
  ssc_pkg::ssc_flags_t flagMeta; // First stage, read only below
  ssc_pkg::ssc_flags_t flagSync; // Safe copy
  logic burstEndLast; // For edge detect
  logic oscLast; // For edge detect

  // Two stages before any logic looks
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      flagMeta <= '0;
      flagSync <= '0;
      burstEndLast <= 1'b0;
      oscLast <= 1'b0;
    end else begin
      flagMeta <= flagsIn;
      flagSync <= flagMeta;
      burstEndLast <= flagSync.burstEnd;
      oscLast <= flagSync.oscAbnormal;
    end
  end

  // ****************************************
  // Bus address phase
  // ****************************************
  logic addrTake; // Transfer accepted
  logic addrMapped; // Address inside window
  logic [7:0] addrIdx; // Register index
  logic wrPend; // Write data phase pending
  logic [7:0] wrIdx; // Index of pending write
  logic wrHit; // Data phase write strobe

  assign addrTake = hsel && htrans[1] && hready;
  assign addrMapped = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
  assign addrIdx = haddr[9:2];
  // Capture writes for their data phase; zero wait, always OKAY
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      wrPend <= 1'b0;
      wrIdx <= ssc_pkg::RST_REG;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wrPend <= addrTake && hwrite && addrMapped;
      wrIdx <= addrIdx;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  assign wrHit = wrPend;

  // ****************************************
  // Software-written registers
  // ****************************************
  logic [7:0] busSelReg; // Bus select, spare bits kept
  logic [7:0] wdogEnReg; // Watchdog enables
  logic [7:0] ctrlOneReg; // Driver fault logic enable
  logic [4:0] nvmSpare; // Spare read/write bits 7..3
  logic stat1Spare; // Spare bit 7 of status one
  logic [1:0] stat2Spare; // Spare bits 7..6 of status two

  // Plain storage registers
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      busSelReg <= ssc_pkg::RST_REG;
      wdogEnReg <= ssc_pkg::RST_REG;
      ctrlOneReg <= ssc_pkg::RST_REG;
      nvmSpare <= '0;
      stat1Spare <= 1'b0;
      stat2Spare <= '0;
    end else if (wrHit) begin
      case (wrIdx)
        ssc_pkg::IDX_BUS_SEL: busSelReg <= hwdata[7:0];
        ssc_pkg::IDX_WDOG_EN: wdogEnReg <= hwdata[7:0];
        ssc_pkg::IDX_CTRL_ONE: ctrlOneReg <= hwdata[7:0];
        ssc_pkg::IDX_NVM_CTRL: nvmSpare <= hwdata[7:3];
        ssc_pkg::IDX_STATUS_ONE: stat1Spare <= hwdata[7];
        ssc_pkg::IDX_STATUS_TWO: stat2Spare <= hwdata[7:6];
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end
  end

  // Routing output straight from storage
  assign busModeSerial = busSelReg[ssc_pkg::BIT_BUS_MODE];

  // Serial length, clamped so hardware never exceeds eight bytes
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      serialXferLen <= ssc_pkg::SER_MAX_BYTES;
    end else if (wrHit && wrIdx == ssc_pkg::IDX_SER_LEN) begin
      serialXferLen <= (hwdata[7:0] > 8'(ssc_pkg::SER_MAX_BYTES)) ? ssc_pkg::SER_MAX_BYTES : hwdata[3:0];
    end
  end

  // ****************************************
  // Nonvolatile memory control
  // ****************************************
  logic nvmWr; // Write to control register
  logic progReq; // New programming request
  logic progBusy; // Programming in progress

  assign nvmWr = wrHit && (wrIdx == ssc_pkg::IDX_NVM_CTRL);
  assign progReq = nvmWr && hwdata[ssc_pkg::BIT_PROG] && !progBusy;

  // Start strobes, one cycle each; zero writes do nothing
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      nvmReloadStart <= 1'b0;
      nvmProgramStart <= 1'b0;
    end else begin
      nvmReloadStart <= nvmWr && hwdata[ssc_pkg::BIT_RELOAD];
      nvmProgramStart <= progReq;
    end
  end

  // Busy: a new start wins over a done in the same cycle
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      progBusy <= 1'b0;
    end else if (progReq || nvmProgramDone) begin
      progBusy <= progReq;
    end
  end

  // ****************************************
  // Saturation timing
  // ****************************************
  ssc_pkg::ssc_sat_state_t satState; // Timing state
  logic [15:0] satCnt; // Cycles since burst end
  logic [15:0] satTime; // Recorded elapsed time
  logic satDoneFlag; // Envelope fell below threshold
  logic burstEdge; // Burst just finished

  assign burstEdge = flagSync.burstEnd && !burstEndLast;

  // Time from burst end to envelope below threshold
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      satState <= ssc_pkg::SAT_IDLE;
      satCnt <= '0;
      satTime <= '0;
      satDoneFlag <= 1'b0;
    end else begin
      case (satState)
        ssc_pkg::SAT_IDLE, ssc_pkg::SATURATION_DONE: begin
          if (burstEdge) begin
            satState <= ssc_pkg::SAT_WAIT;
            satCnt <= '0;
            satDoneFlag <= 1'b0;
          end
        end
        ssc_pkg::SAT_WAIT: begin
          if (flagSync.echoBelow) begin
            satState <= ssc_pkg::SATURATION_DONE;
            satTime <= satCnt;
            satDoneFlag <= 1'b1;
          end else if (satCnt != ssc_pkg::SAT_CNT_MAX) begin
            satCnt <= satCnt + 16'h0001; // Saturates, never wraps
          end
        end
        default: begin
          satState <= ssc_pkg::SAT_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Watchdogs
  // ****************************************
  logic swWdEn; // Software watchdog enabled
  logic oscWdEn; // Oscillator watchdog enabled
  logic [31:0] wdogCnt; // Cycles since last service
  logic swTimeout; // Software watchdog expired
  logic wdogExpire; // Last cycle of the window
  logic wdogKick; // Service write

  assign swWdEn = wdogEnReg[ssc_pkg::BIT_SW_WATCHDOG_ENABLE];
  assign oscWdEn = wdogEnReg[ssc_pkg::BIT_OSC_WATCHDOG_ENABLE];
  assign wdogKick = wrHit && (wrIdx == ssc_pkg::IDX_WDOG_KICK);
  assign wdogExpire = swWdEn && (wdogCnt == 32'(SW_WDOG_CYCLES - 1));

  // Service window counter; idle and cleared while disabled
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      wdogCnt <= '0;
    end else if (!swWdEn || wdogKick || wdogExpire) begin
      wdogCnt <= '0;
    end else begin
      wdogCnt <= wdogCnt + 32'h0000_0001;
    end
  end

  // Timeout is sticky: it must survive the core reset it causes
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      swTimeout <= 1'b0;
      coreReset <= 1'b0;
    end else begin
      if (wdogExpire) begin
        swTimeout <= 1'b1;
      end
      coreReset <= wdogExpire || (oscWdEn && flagSync.oscAbnormal && !oscLast);
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  logic [7:0] statusOne; // Power and self-test status
  logic [7:0] statusTwo; // Regulator, watchdog, driver status
  logic drvEn; // Driver fault logic enabled

  assign drvEn = ctrlOneReg[ssc_pkg::BIT_DRV_FLT_EN];
  // Live conditions; reading changes nothing
  assign statusOne = {stat1Spare, flagSync.trimCorrupt,
                      !flagSync.selftestDone,
                      !flagSync.selftestPass,
                      flagSync.supplyOv, flagSync.avddUv, flagSync.avddOc,
                      flagSync.biasOc};
  assign statusTwo = {stat2Spare,
                      oscWdEn && flagSync.oscAbnormal,
                      drvEn && flagSync.drvBFault,
                      drvEn && flagSync.drvAFault,
                      swTimeout, satDoneFlag,
                      flagSync.regReady};

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] readByte; // Selected register

  // Write-only bits read as zero; unmapped reads zero
  always_comb begin
    readByte = 8'h00;
    case (addrIdx)
      ssc_pkg::IDX_WDOG_EN: readByte = wdogEnReg;
      ssc_pkg::IDX_BUS_SEL: readByte = busSelReg;
      ssc_pkg::IDX_NVM_CTRL: readByte = {nvmSpare, 2'b00, progBusy};
      ssc_pkg::IDX_STATUS_ONE: readByte = statusOne;
      ssc_pkg::IDX_STATUS_TWO: readByte = statusTwo;
      ssc_pkg::IDX_CTRL_ONE: readByte = ctrlOneReg;
      ssc_pkg::IDX_SATURATION_TIME: readByte = satTime[7:0];
      ssc_pkg::IDX_SER_LEN: readByte = {4'h0, serialXferLen};
      default: readByte = 8'h00;
    endcase
  end

  // Sampled at the address phase, stands through the data phase
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      hrdata <= ssc_pkg::RDATA_ZERO;
    end else if (addrTake && !hwrite) begin
      if (!addrMapped) begin
        hrdata <= ssc_pkg::RDATA_ZERO;
      end else if (addrIdx == ssc_pkg::IDX_SATURATION_TIME) begin
        hrdata <= {16'h0000, satTime};
      end else begin
        hrdata <= {24'h00_0000, readByte};
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [1:0] aliveCnt; // Lets synchronisers fill after reset
  // Saturating count of cycles since release
  always_ff @(posedge core_clk or negedge rstSync) begin
    if (!rstSync) begin
      aliveCnt <= 2'b00;
    end else if (aliveCnt != 2'b11) begin
      aliveCnt <= aliveCnt + 2'b01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSync);
  sequence s_nvm_wr(int b);
    nvmWr && hwdata[b];
  endsequence
  property p_bus_mode;
    wrHit && wrIdx == ssc_pkg::IDX_BUS_SEL |=> busModeSerial == $past(hwdata[0]);
  endproperty
  a_bus_mode: assert property (p_bus_mode) else $error("bus mode not updated");
  property p_ser_len;
    serialXferLen <= ssc_pkg::SER_MAX_BYTES;
  endproperty
  a_ser_len: assert property (p_ser_len) else $error("serial length above limit");
  property p_reload;
    nvmReloadStart |-> $past(nvmWr && hwdata[1]) ##1 !nvmReloadStart;
  endproperty
  a_reload: assert property (p_reload) else $error("reload strobe wrong");
  property p_prog_start;
    s_nvm_wr(0) and !progBusy |=> nvmProgramStart && progBusy;
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("programming did not start");
  // A start is refused while busy, so a done always clears
  property p_busy_clear;
    progBusy && nvmProgramDone |=> !progBusy;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");
  property p_trim;
    aliveCnt == 2'b11 |-> statusOne[6] == $past(flagsIn.trimCorrupt, 2);
  endproperty
  a_trim: assert property (p_trim) else $error("trim flag mismatch");
  property p_selftest;
    aliveCnt == 2'b11 |-> statusOne[5:4] == ~{$past(flagsIn.selftestDone, 2), $past(flagsIn.selftestPass, 2)};
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test flags mismatch");
  property p_sat;
    satState == ssc_pkg::SAT_WAIT && flagSync.echoBelow |=> satDoneFlag && satTime == $past(satCnt);
  endproperty
  a_sat: assert property (p_sat) else $error("saturation not recorded");
  property p_wdog;
    wdogExpire |=> coreReset && swTimeout && wdogCnt == 32'h0000_0000;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog expiry missed");
  property p_drv;
    !drvEn |-> statusTwo[4:3] == 2'b00;
  endproperty
  a_drv: assert property (p_drv) else $error("driver fault while disabled");
endmodule : ssc_status_control_regs

// ==== testbench/ssc_status_control_regs_tb_top.sv ====
// Purpose: Self-checking bench for the sensor status/control register bank
// Assumes: Zero-wait AHB-Lite slave, shortened software watchdog window
// Notes: Registered outputs are read right after an edge, so they show pre-edge values
`timescale 1ns/100ps
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin errorCnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module ssc_status_control_regs_tb_top;
  // ****************************************
  // Bench signals
  // ****************************************
  localparam int WD_CYC = 50; // Short watchdog window
  localparam logic [12:0] BASE = 13'h0C00; // Self-test done and passed
  logic core_clk; // 10 MHz clock
  logic rst_n; // Active-low reset
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout; // Also the bus hready
  logic [31:0] hrdata;
  logic hresp;
  ssc_pkg::ssc_flags_t flagsIn; // Condition levels
  logic nvmProgramDone;
  logic nvmReloadStart;
  logic nvmProgramStart;
  logic busModeSerial;
  logic [3:0] serialXferLen;
  logic coreReset;
  int errorCnt = 0; // Mismatches
  int nTests = 0; // Comparisons
  int cycles = 0; // Hang guard
  int reloadCnt = 0; // Pulse tallies
  int progCnt = 0;
  int resetCnt = 0;
  logic [31:0] rd; // Last read word

  // ****************************************
  // Design under test
  // ****************************************
  ssc_status_control_regs #(.SW_WDOG_CYCLES(WD_CYC)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flagsIn(flagsIn),
    .nvmProgramDone(nvmProgramDone), .nvmReloadStart(nvmReloadStart),
    .nvmProgramStart(nvmProgramStart), .busModeSerial(busModeSerial),
    .serialXferLen(serialXferLen), .coreReset(coreReset)
  );

  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Pulse tallies; counting beats catching a one-cycle pulse by hand
  always @(posedge core_clk) begin
    if (nvmReloadStart === 1'b1) reloadCnt++;
    if (nvmProgramStart === 1'b1) progCnt++;
    if (coreReset === 1'b1) resetCnt++;
  end

  // Hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errorCnt++;
      end_of_test();
    end
  end

  // ****************************************
  // Bus and helper tasks
  // ****************************************
  // One single word transfer; master holds each phase until hready is seen
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= 32'(idx) << 2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= 32'(wd);
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  // Register write
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask : wr

  // Register read and compare; upper bits must read zero
  task automatic chk_reg(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, rd);
    `CHK(rd, 32'(e))
    `CHK(hresp, 1'b0)
  endtask : chk_reg

  // Apply condition levels and let them pass the synchroniser
  task automatic set_flags(input logic [12:0] f);
    @(posedge core_clk);
    flagsIn <= f;
    repeat (3) @(posedge core_clk);
  endtask : set_flags

  // ****************************************
  // Scenarios
  // ****************************************
  // Reset values, serial length default, empty index
  task automatic t_reset;
    chk_reg(ssc_pkg::IDX_BUS_SEL, 8'h00);
    chk_reg(ssc_pkg::IDX_NVM_CTRL, 8'h00);
    chk_reg(ssc_pkg::IDX_WDOG_EN, 8'h00);
    chk_reg(ssc_pkg::IDX_STATUS_ONE, 8'h00);
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h00);
    `CHK(serialXferLen, 4'h8)
    wr(8'h00, 8'hFF);
    chk_reg(8'h00, 8'h00);
  endtask : t_reset

  // Bus mode routing both ways, spare bits writable
  task automatic t_bus_mode;
    wr(ssc_pkg::IDX_BUS_SEL, 8'h01);
    @(negedge core_clk);
    `CHK(busModeSerial, 1'b1)
    wr(ssc_pkg::IDX_BUS_SEL, 8'hFE);
    @(negedge core_clk);
    `CHK(busModeSerial, 1'b0)
    chk_reg(ssc_pkg::IDX_BUS_SEL, 8'hFE);
  endtask : t_bus_mode

  // Serial transfer length clamps at eight
  task automatic t_serial_len;
    wr(ssc_pkg::IDX_SER_LEN, 8'h03);
    @(negedge core_clk);
    `CHK(serialXferLen, 4'h3)
    wr(ssc_pkg::IDX_SER_LEN, 8'h0F);
    @(negedge core_clk);
    `CHK(serialXferLen, 4'h8)
  endtask : t_serial_len

  // Reload, program start, busy and its automatic clear
  task automatic t_nvm;
    int r0;
    int p0;
    r0 = reloadCnt;
    p0 = progCnt;
    wr(ssc_pkg::IDX_NVM_CTRL, 8'h02);
    repeat (2) @(posedge core_clk);
    `CHK(reloadCnt, r0 + 1)
    chk_reg(ssc_pkg::IDX_NVM_CTRL, 8'h00);
    wr(ssc_pkg::IDX_NVM_CTRL, 8'h00);
    repeat (2) @(posedge core_clk);
    `CHK(reloadCnt + progCnt, r0 + p0 + 1)
    wr(ssc_pkg::IDX_NVM_CTRL, 8'h01);
    chk_reg(ssc_pkg::IDX_NVM_CTRL, 8'h01);
    `CHK(progCnt, p0 + 1)
    wr(ssc_pkg::IDX_NVM_CTRL, 8'h01);
    chk_reg(ssc_pkg::IDX_NVM_CTRL, 8'h01);
    `CHK(progCnt, p0 + 1)
    @(posedge core_clk);
    nvmProgramDone <= 1'b1;
    @(posedge core_clk);
    nvmProgramDone <= 1'b0;
    chk_reg(ssc_pkg::IDX_NVM_CTRL, 8'h00);
  endtask : t_nvm

  // Each status one flag alone, inverted self-test senses included
  task automatic t_status_one;
    for (int i = 0; i < 7; i++) begin
      set_flags(BASE ^ (13'h0001 << (6 + i)));
      chk_reg(ssc_pkg::IDX_STATUS_ONE, 8'h01 << i);
    end
    set_flags(BASE);
    wr(ssc_pkg::IDX_STATUS_ONE, 8'hFF);
    chk_reg(ssc_pkg::IDX_STATUS_ONE, 8'h80);
    chk_reg(ssc_pkg::IDX_STATUS_ONE, 8'h80);
  endtask : t_status_one

  // Regulator ready, enable gating of driver and oscillator flags
  task automatic t_status_two;
    int c0;
    set_flags(BASE | 13'h0020);
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h01);
    set_flags(BASE | 13'h001C);
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h00);
    wr(ssc_pkg::IDX_CTRL_ONE, 8'h01);
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h18);
    wr(ssc_pkg::IDX_CTRL_ONE, 8'h00);
    set_flags(BASE);
    wr(ssc_pkg::IDX_WDOG_EN, 8'h01);
    c0 = resetCnt;
    set_flags(BASE | 13'h0010);
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h20);
    `CHK(resetCnt, c0 + 1)
    wr(ssc_pkg::IDX_WDOG_EN, 8'h00);
    set_flags(BASE);
  endtask : t_status_two

  // Serviced watchdog stays quiet, starved one resets the core once
  task automatic t_watchdog;
    int c0;
    c0 = resetCnt;
    wr(ssc_pkg::IDX_WDOG_EN, 8'h02);
    repeat (3) begin
      repeat (30) @(posedge core_clk);
      wr(ssc_pkg::IDX_WDOG_KICK, 8'h00);
    end
    `CHK(resetCnt, c0)
    repeat (70) @(posedge core_clk);
    `CHK(resetCnt, c0 + 1)
    wr(ssc_pkg::IDX_WDOG_EN, 8'h00);
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h04);
    chk_reg(ssc_pkg::IDX_WDOG_EN, 8'h00);
  endtask : t_watchdog

  // Wait for regulator ready, then burst end to echo below threshold, twelve cycles apart
  task automatic t_saturation;
    set_flags(BASE | 13'h0020);
    do bus(1'b0, ssc_pkg::IDX_STATUS_TWO, 8'h00, rd); while (rd[0] !== 1'b1);
    `CHK(rd, 32'h0000_0005)
    @(posedge core_clk);
    flagsIn <= BASE | 13'h0021;
    repeat (12) @(posedge core_clk);
    flagsIn <= BASE | 13'h0023;
    repeat (3) @(posedge core_clk);
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h07);
    bus(1'b0, ssc_pkg::IDX_SATURATION_TIME, 8'h00, rd);
    `CHK((rd >= 32'h0000_000B) && (rd <= 32'h0000_000D), 1'b1)
  endtask : t_saturation

  // Mid-run reset clears the sticky timeout; first read still sees synchroniser reset values
  task automatic t_rerun;
    set_flags(BASE | 13'h0020);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h00);
    chk_reg(ssc_pkg::IDX_BUS_SEL, 8'h00);
    `CHK(serialXferLen, 4'h8)
    chk_reg(ssc_pkg::IDX_STATUS_TWO, 8'h01);
  endtask : t_rerun

  // ****************************************
  // Verdict
  // ****************************************
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    flagsIn = BASE;
    nvmProgramDone = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_bus_mode();
    t_serial_len();
    t_nvm();
    t_status_one();
    t_status_two();
    t_watchdog();
    t_saturation();
    t_rerun();
    end_of_test();
  end
endmodule : ssc_status_control_regs_tb_top
